//--- rtl/wdtr_map.svh
// Register map, field positions, reset values and counts of the watchdog
`ifndef WDTR_MAP_SVH
`define WDTR_MAP_SVH
`define WDTR_ADDR_W        12
`define WDTR_OFF_CTL       12'h000
`define WDTR_OFF_IER       12'h004
`define WDTR_OFF_ISR       12'h008
`define WDTR_CTL_RST       32'h0000_0070
`define WDTR_CTL_CLR_BIT   0
`define WDTR_CTL_RSTEN_BIT 1
`define WDTR_CTL_WKEN_BIT  2
`define WDTR_CTL_EN_BIT    3
`define WDTR_CTL_IS_LSB    4
`define WDTR_CTL_IS_MSB    6
`define WDTR_CTL_DLY_LSB   8
`define WDTR_CTL_DLY_MSB   9
`define WDTR_IER_IE_BIT    0
`define WDTR_ISR_TO_BIT    0
`define WDTR_ISR_RST_BIT   1
`define WDTR_ISR_WAKE_BIT  2
`define WDTR_IS_RST        3'h7
`define WDTR_DLY_RST       2'h0
`define WDTR_CNT_W         18
`define WDTR_PH_W          11
`define WDTR_DLY_00        11'h402
`define WDTR_DLY_01        11'h082
`define WDTR_DLY_10        11'h012
`define WDTR_DLY_11        11'h003
`define WDTR_HOLD_CLKS     63
`define WDTR_IVL_BASE_EXP  5'h04
`endif

//--- rtl/wdtr_pkg.sv
// Types of the watchdog timer
package wdtr_pkg;
`include "wdtr_map.svh"

  typedef enum logic [1:0] {
    PH_RUN   = 2'b00,
    PH_DELAY = 2'b01,
    PH_HOLD  = 2'b10
  } wdtr_phase_type;

  typedef struct packed {
    logic                   clkSync1;
    logic                   clkSync2;
    logic                   clkPrev;
    logic                   pdPrev;
    logic [2:0]             intervalSel;
    logic                   timerEn;
    logic                   wakeEn;
    logic                   resetEn;
    logic                   clearBit;
    logic [1:0]             delaySel;
    logic                   intEn;
    logic                   toFlag;
    logic                   rstFlag;
    logic                   wakeFlag;
    logic                   wakeAged;
    logic [`WDTR_CNT_W-1:0] counter;
    wdtr_phase_type         phase;
    logic [`WDTR_PH_W-1:0]  phaseCnt;
    logic                   cpuReset;
    logic                   irq;
    logic                   wakeReq;
    logic                   pready;
    logic                   pslverr;
    logic [31:0]            prdata;
  } wdtr_state_type;
endpackage

//--- rtl/wdtr_top.sv
// Watchdog timer with wake-up, APB slave, counters and CPU reset hold
//
// Our own choice: register access over APB.
`timescale 1ns/1ps
`include "wdtr_map.svh"

module wdtr_top #(
  parameter int HOLD_CLKS = `WDTR_HOLD_CLKS
) (
  // Clock and reset
  input  wire logic                    clk,
  input  wire logic                    rst_n,
  // APB slave
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [`WDTR_ADDR_W-1:0] paddr,
  input  wire logic [31:0]             pwdata,
  output logic      [31:0]             prdata,
  output logic                         pready,
  output logic                         pslverr,
  // System
  input  wire logic                    wdtClk,
  input  wire logic                    powerDown,
  input  wire logic                    unlockActive,
  output logic                         cpuReset,
  output logic                         irq,
  output logic                         wakeReq
);
  import wdtr_pkg::*;

  localparam logic [`WDTR_PH_W-1:0] HOLD_LEN = `WDTR_PH_W'(HOLD_CLKS);

  if (HOLD_CLKS < 1 || HOLD_CLKS > 1023) begin : g_hold_check
    $error("HOLD_CLKS out of range");
  end

  function automatic logic [`WDTR_CNT_W:0] intervalLen(input logic [2:0] sel);
    logic [4:0] sh;
    sh = `WDTR_IVL_BASE_EXP + {1'b0, sel, 1'b0};
    return (`WDTR_CNT_W+1)'(1) << sh;
  endfunction

  function automatic logic [`WDTR_PH_W-1:0] delayLen(input logic [1:0] sel);
    logic [`WDTR_PH_W-1:0] len;
    case (sel)
      2'h0:    len = `WDTR_DLY_00;
      2'h1:    len = `WDTR_DLY_01;
      2'h2:    len = `WDTR_DLY_10;
      default: len = `WDTR_DLY_11;
    endcase
    return len;
  endfunction

  wdtr_state_type s;
  wdtr_state_type n;

  logic        tick;
  logic        accFirst;
  logic        wrDone;
  logic        wrCtl;
  logic        wrIer;
  logic        wrIsr;
  logic        clearReq;
  logic        pdEnter;
  logic        timeoutEv;
  logic        delayExp;
  logic        holdEnd;
  logic        rstEv;
  logic        wakeEv;
  logic        mapped;
  logic [31:0] rdMux;

  // Event decode from present state
  assign tick      = s.clkSync2 & ~s.clkPrev;
  assign accFirst  = psel & penable & ~s.pready;
  assign wrDone    = psel & penable & pwrite & s.pready;
  assign wrCtl     = wrDone & (paddr == `WDTR_OFF_CTL);
  assign wrIer     = wrDone & (paddr == `WDTR_OFF_IER);
  assign wrIsr     = wrDone & (paddr == `WDTR_OFF_ISR);
  assign clearReq  = wrCtl & unlockActive & pwdata[`WDTR_CTL_CLR_BIT];
  assign pdEnter   = powerDown & ~s.pdPrev;
  assign timeoutEv = tick & s.timerEn &
                     (({1'b0, s.counter} + 1'b1) == intervalLen(s.intervalSel));
  assign delayExp  = tick & (s.phase == PH_DELAY) &
                     ((s.phaseCnt + 1'b1) == delayLen(s.delaySel));
  assign holdEnd   = tick & (s.phase == PH_HOLD) &
                     ((s.phaseCnt + 1'b1) == HOLD_LEN);
  assign rstEv     = delayExp & s.resetEn;
  assign wakeEv    = timeoutEv & powerDown;
  assign mapped    = (paddr == `WDTR_OFF_CTL) | (paddr == `WDTR_OFF_IER) |
                     (paddr == `WDTR_OFF_ISR);

  always_comb begin
    rdMux = 32'h0;
    case (paddr)
      `WDTR_OFF_CTL: begin
        rdMux[`WDTR_CTL_DLY_MSB:`WDTR_CTL_DLY_LSB] = s.delaySel;
        rdMux[`WDTR_CTL_IS_MSB:`WDTR_CTL_IS_LSB]   = s.intervalSel;
        rdMux[`WDTR_CTL_EN_BIT]    = s.timerEn;
        rdMux[`WDTR_CTL_WKEN_BIT]  = s.wakeEn;
        rdMux[`WDTR_CTL_RSTEN_BIT] = s.resetEn;
        rdMux[`WDTR_CTL_CLR_BIT]   = s.clearBit;
      end
      `WDTR_OFF_IER: rdMux[`WDTR_IER_IE_BIT] = s.intEn;
      `WDTR_OFF_ISR: begin
        rdMux[`WDTR_ISR_TO_BIT]   = s.toFlag;
        rdMux[`WDTR_ISR_RST_BIT]  = s.rstFlag;
        rdMux[`WDTR_ISR_WAKE_BIT] = s.wakeFlag;
      end
      default: rdMux = 32'h0;
    endcase
  end

  always_comb begin
    n = s;
    // Two-flop synchroniser on the watchdog clock pin
    n.clkSync1 = wdtClk;
    n.clkSync2 = s.clkSync1;
    n.clkPrev  = s.clkSync2;
    n.pdPrev   = powerDown;

    // APB answer after one wait state
    n.pready  = accFirst;
    n.pslverr = accFirst & ~mapped;
    n.prdata  = (accFirst & ~pwrite) ? rdMux : 32'h0;

    // Control writes
    n.clearBit = 1'b0;
    if (wrCtl) begin
      n.delaySel = pwdata[`WDTR_CTL_DLY_MSB:`WDTR_CTL_DLY_LSB];
      if (unlockActive) begin
        n.intervalSel = pwdata[`WDTR_CTL_IS_MSB:`WDTR_CTL_IS_LSB];
        n.timerEn     = pwdata[`WDTR_CTL_EN_BIT];
        n.wakeEn      = pwdata[`WDTR_CTL_WKEN_BIT];
        n.resetEn     = pwdata[`WDTR_CTL_RSTEN_BIT];
        n.clearBit    = pwdata[`WDTR_CTL_CLR_BIT];
      end
    end
    if (wrIer) begin
      n.intEn = pwdata[`WDTR_IER_IE_BIT];
    end

    // Free-running up-counter
    if (tick && s.timerEn) begin
      n.counter = timeoutEv ? '0 : s.counter + 1'b1;
    end
    if (clearReq || !n.timerEn || pdEnter) begin
      n.counter = '0;
    end

    // Delay window and reset hold
    case (s.phase)
      PH_RUN: begin
        if (timeoutEv) begin
          n.phase    = PH_DELAY;
          n.phaseCnt = '0;
        end
      end
      PH_DELAY: begin
        if (delayExp) begin
          n.phaseCnt = '0;
          if (s.resetEn) begin
            n.phase    = PH_HOLD;
            n.delaySel = `WDTR_DLY_RST;
          end else begin
            n.phase = PH_RUN;
          end
        end else if (tick) begin
          n.phaseCnt = s.phaseCnt + 1'b1;
        end
      end
      PH_HOLD: begin
        if (holdEnd) begin
          n.phase    = PH_RUN;
          n.phaseCnt = '0;
        end else if (tick) begin
          n.phaseCnt = s.phaseCnt + 1'b1;
        end
      end
      default: begin
        n.phase    = PH_RUN;
        n.phaseCnt = '0;
      end
    endcase
    if (n.phase == PH_DELAY && (clearReq || !n.timerEn)) begin
      n.phase    = PH_RUN;
      n.phaseCnt = '0;
    end

    // Sticky flags, set wins over write-one clear
    n.toFlag = (s.toFlag & ~(wrIsr & pwdata[`WDTR_ISR_TO_BIT]))
               | timeoutEv;
    n.rstFlag = (s.rstFlag & ~(wrIsr & pwdata[`WDTR_ISR_RST_BIT]))
                | rstEv;
    n.wakeFlag = (s.wakeFlag & ~(wrIsr & pwdata[`WDTR_ISR_WAKE_BIT]
                 & s.wakeAged)) | wakeEv;
    n.wakeAged = s.wakeFlag & (s.wakeAged | tick) & ~wakeEv;

    // Outputs
    n.irq      = n.toFlag & n.intEn;
    n.cpuReset = (n.phase == PH_HOLD);
    n.wakeReq  = n.wakeFlag & n.wakeEn;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s             <= '0;
      s.intervalSel <= `WDTR_IS_RST;
      s.delaySel    <= `WDTR_DLY_RST;
      s.phase       <= PH_RUN;
    end else begin
      s <= n;
    end
  end

  assign prdata   = s.prdata;
  assign pready   = s.pready;
  assign pslverr  = s.pslverr;
  assign cpuReset = s.cpuReset;
  assign irq      = s.irq;
  assign wakeReq  = s.wakeReq;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence sLockedCtlWrite;
    wrCtl && !unlockActive;
  endsequence

  sequence sExpiryWithReset;
    delayExp && s.resetEn;
  endsequence

  sequence sClearInWindow;
    s.phase == PH_DELAY && !delayExp && clearReq;
  endsequence

  AST_CLR_SELF: assert property (
    clearReq |=> s.clearBit && s.counter == '0 ##1 !s.clearBit)
    else $error("clear bit did not self-clear");

  AST_INTERVAL: assert property (
    tick && s.timerEn && {1'b0, s.counter} ==
    (19'h1 << (`WDTR_IVL_BASE_EXP + 2 * s.intervalSel)) - 19'h1
    |=> s.toFlag && s.counter == '0)
    else $error("time-out at wrong count");

  AST_TO_FLAG: assert property (
    timeoutEv |=> s.toFlag && (s.irq == s.intEn))
    else $error("time-out flag or interrupt wrong");

  AST_DELAY_LEN: assert property (
    tick && s.phase == PH_DELAY && s.phaseCnt + 1'b1 ==
    (s.delaySel == 2'h0 ? `WDTR_DLY_00 : s.delaySel == 2'h1 ? `WDTR_DLY_01 :
     s.delaySel == 2'h2 ? `WDTR_DLY_10 : `WDTR_DLY_11)
    |=> s.phase != PH_DELAY)
    else $error("delay window length wrong");

  AST_RESET_SEQ: assert property (
    sExpiryWithReset |=> s.cpuReset && s.rstFlag &&
                         s.delaySel == `WDTR_DLY_RST)
    else $error("watchdog reset not raised");

  AST_HOLD_LEN: assert property (
    $fell(s.cpuReset) |-> $past(s.phaseCnt) + 1'b1 == HOLD_LEN)
    else $error("CPU reset hold length wrong");

  AST_DISABLED: assert property (
    !s.timerEn |-> s.counter == '0 && s.phase != PH_DELAY)
    else $error("disabled watchdog still counting");

  AST_PD_CLEAR: assert property (
    pdEnter |=> s.counter == '0)
    else $error("counter not zeroed on power-down");

  AST_WAKE: assert property (
    wakeEv |=> s.wakeFlag && s.toFlag ##1 s.wakeReq == s.wakeEn)
    else $error("wake-up flags or request wrong");

  AST_NO_RESET: assert property (
    delayExp && !s.resetEn |=> !s.cpuReset && !$rose(s.rstFlag))
    else $error("reset acted with reset function off");

  AST_LOCKED: assert property (
    sLockedCtlWrite |=> $stable(s.timerEn) && $stable(s.intervalSel) &&
                        $stable(s.resetEn) && $stable(s.wakeEn))
    else $error("protected field changed while locked");

  AST_RST_FLAG_HOLD: assert property (
    s.rstFlag && !(wrIsr && pwdata[`WDTR_ISR_RST_BIT]) |=> s.rstFlag)
    else $error("reset flag lost");

  AST_COUNT_STEP: assert property (
    tick && s.timerEn && !timeoutEv && !wrCtl && !pdEnter
    |=> s.counter == $past(s.counter) + 1'b1)
    else $error("counter did not step by one");

  AST_TO_NO_IRQ: assert property (
    timeoutEv && !s.intEn && !wrIer |=> s.toFlag && !s.irq)
    else $error("time-out flag wrong with interrupt off");

  AST_TO_CLEAR: assert property (
    wrIsr && pwdata[`WDTR_ISR_TO_BIT] && !timeoutEv |=> !s.toFlag)
    else $error("time-out flag not cleared");

  AST_DELAY_START: assert property (
    timeoutEv && s.phase == PH_RUN && !wrCtl
    |=> s.phase == PH_DELAY && s.phaseCnt == '0)
    else $error("delay window did not start");

  AST_DELAY_STEP: assert property (
    tick && s.phase == PH_DELAY && !delayExp && !wrCtl
    |=> s.phase == PH_DELAY && s.phaseCnt == $past(s.phaseCnt) + 1'b1)
    else $error("delay window did not advance");

  AST_CANCEL: assert property (
    sClearInWindow |=> s.phase == PH_RUN && s.counter == '0 && !s.cpuReset)
    else $error("clear in window did not cancel reset");

  AST_CPU_RESET_CAUSE: assert property (
    $rose(s.cpuReset) |-> s.rstFlag && $past(s.phase) == PH_DELAY)
    else $error("CPU reset without expiry");

  AST_HOLD_ON: assert property (
    s.phase == PH_HOLD && !holdEnd |=> s.cpuReset)
    else $error("CPU reset dropped during hold");

  AST_DISABLE_ZERO: assert property (
    wrCtl && unlockActive && !pwdata[`WDTR_CTL_EN_BIT]
    |=> !s.timerEn && s.counter == '0)
    else $error("disable did not zero counter");

  AST_WAKE_REQ: assert property (
    s.wakeFlag && s.wakeEn && !wrIsr && !wrCtl |=> s.wakeReq)
    else $error("wake-up request missing");

  AST_WAKE_ONLY_PD: assert property (
    $rose(s.wakeFlag) |-> $past(powerDown) && s.toFlag)
    else $error("wake-up flag outside power-down");

  AST_WAKE_EARLY: assert property (
    wrIsr && pwdata[`WDTR_ISR_WAKE_BIT] && s.wakeFlag && !s.wakeAged
    |=> s.wakeFlag)
    else $error("wake-up flag cleared too early");

  AST_WAKE_CLEAR: assert property (
    wrIsr && pwdata[`WDTR_ISR_WAKE_BIT] && s.wakeAged && !wakeEv
    |=> !s.wakeFlag)
    else $error("wake-up flag not cleared");

  AST_RST_FLAG_CLEAR: assert property (
    wrIsr && pwdata[`WDTR_ISR_RST_BIT] && !rstEv |=> !s.rstFlag)
    else $error("reset flag not cleared");

  AST_RST_ONLY_EXPIRY: assert property (
    $rose(s.rstFlag) |-> $past(s.resetEn) && $past(s.phase) == PH_DELAY)
    else $error("reset flag set without enabled expiry");

  AST_CLR_LOCKED: assert property (
    sLockedCtlWrite |=> !s.clearBit)
    else $error("clear bit set while locked");
endmodule

//--- verif/test_watchdog_timer_with_wakeup.sv
// Self-checking bench of the watchdog timer with wake-up
`timescale 1ns/1ps
`include "wdtr_map.svh"
module test_watchdog_timer_with_wakeup;
  localparam int HOLD = 4;
  logic                    clk;
  logic                    rst_n;
  logic                    psel;
  logic                    penable;
  logic                    pwrite;
  logic [`WDTR_ADDR_W-1:0] paddr;
  logic [31:0]             pwdata;
  logic [31:0]             prdata;
  logic [31:0]             rd;
  logic [31:0]             d;
  logic                    pready;
  logic                    pslverr;
  logic                    err;
  logic                    wdtClk;
  logic                    powerDown;
  logic                    unlockActive;
  logic                    cpuReset;
  logic                    irq;
  logic                    wakeReq;
  int                      failures;
  int                      checks;

  wdtr_top #(.HOLD_CLKS(HOLD)) u_dut (
    .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .wdtClk(wdtClk),
    .powerDown(powerDown), .unlockActive(unlockActive),
    .cpuReset(cpuReset), .irq(irq), .wakeReq(wakeReq)
  );

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  function automatic int ivl(int sel);
    return 1 << (`WDTR_IVL_BASE_EXP + 2 * sel);
  endfunction

  task automatic stop_test();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(logic [32:0] got, logic [32:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask

  // One APB transfer, entered just after a rising edge
  task automatic apb(logic w, logic [`WDTR_ADDR_W-1:0] a, logic [31:0] wd);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      failures++;
      $display("BAD %0t no pready", $time);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rc(logic [`WDTR_ADDR_W-1:0] a, logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  task automatic wctl(logic [31:0] v);
    unlockActive <= 1'b1;
    apb(1'b1, `WDTR_OFF_CTL, v);
    unlockActive <= 1'b0;
  endtask

  // Watchdog clock well below a quarter of the bus clock
  task automatic tick(int n);
    repeat (n) begin
      wdtClk <= 1'b1;
      repeat (4) @(posedge clk);
      wdtClk <= 1'b0;
      repeat (4) @(posedge clk);
    end
  endtask

  initial begin
    #500000;
    failures++;
    $display("BAD %0t run too long", $time);
    stop_test();
  end

  initial begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = 32'h0;
    wdtClk = 1'b0;
    powerDown = 1'b0;
    unlockActive = 1'b0;
    failures = 0;
    checks = 0;
    d = $urandom(32'h95f39b11);
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rc(`WDTR_OFF_CTL, `WDTR_CTL_RST);
    rc(`WDTR_OFF_IER, 32'h0);
    rc(`WDTR_OFF_ISR, 32'h0);
    apb(1'b0, 12'h00c, 32'h0);
    chk({err, rd}, {1'b1, 32'h0});
    repeat (4) begin
      d = $urandom();
      apb(1'b1, `WDTR_OFF_IER, d);
      rc(`WDTR_OFF_IER, {31'h0, d[0]});
      apb(1'b1, `WDTR_OFF_CTL, d);
      rc(`WDTR_OFF_CTL, 32'h70 | {22'h0, d[9:8], 8'h0});
    end
    apb(1'b1, `WDTR_OFF_IER, 32'h1);
    wctl(32'h0000_030a);
    rc(`WDTR_OFF_CTL, 32'h0000_030a);
    tick(ivl(0) - 1);
    chk(irq, 1'b0);
    rc(`WDTR_OFF_ISR, 32'h0);
    tick(1);
    rc(`WDTR_OFF_ISR, 32'h1);
    chk(irq, 1'b1);
    tick(1);
    chk(cpuReset, 1'b0);
    tick(2);
    chk(cpuReset, 1'b1);
    rc(`WDTR_OFF_ISR, 32'h3);
    rc(`WDTR_OFF_CTL, 32'h0000_000a);
    tick(2);
    chk(cpuReset, 1'b1);
    tick(HOLD);
    chk(cpuReset, 1'b0);
    rc(`WDTR_OFF_ISR, 32'h3);
    wctl(32'h0);
    apb(1'b1, `WDTR_OFF_ISR, 32'h3);
    rc(`WDTR_OFF_ISR, 32'h0);
    wctl(32'h0000_020a);
    tick(10);
    wctl(32'h0);
    wctl(32'h0000_020a);
    tick(10);
    rc(`WDTR_OFF_ISR, 32'h0);
    tick(ivl(0) - 10);
    rc(`WDTR_OFF_ISR, 32'h1);
    tick(10);
    wctl(32'h0000_020b);
    rc(`WDTR_OFF_CTL, 32'h0000_020a);
    tick(12);
    chk(cpuReset, 1'b0);
    rc(`WDTR_OFF_ISR, 32'h1);
    wctl(32'h0);
    apb(1'b1, `WDTR_OFF_ISR, 32'h1);
    apb(1'b1, `WDTR_OFF_IER, 32'h0);
    wctl(32'h0000_0308);
    tick(ivl(0) + 5);
    chk({cpuReset, irq}, 2'b00);
    rc(`WDTR_OFF_ISR, 32'h1);
    wctl(32'h0);
    apb(1'b1, `WDTR_OFF_ISR, 32'h1);
    wctl(32'h0000_000c);
    tick(10);
    powerDown <= 1'b1;
    tick(10);
    rc(`WDTR_OFF_ISR, 32'h0);
    tick(ivl(0) - 10);
    rc(`WDTR_OFF_ISR, 32'h5);
    chk(wakeReq, 1'b1);
    apb(1'b1, `WDTR_OFF_ISR, 32'h4);
    rc(`WDTR_OFF_ISR, 32'h5);
    tick(1);
    apb(1'b1, `WDTR_OFF_ISR, 32'h5);
    rc(`WDTR_OFF_ISR, 32'h0);
    chk(wakeReq, 1'b0);
    powerDown <= 1'b0;
    stop_test();
  end
endmodule
